/* File: hw/dcr_pkg.sv */
// Constants for the DRAM configuration register pair.
// Assumes a 10 MHz clock and an index latched outside this block.
package dcr_pkg;
	// ---------------------------------------------
	// Port and index decode
	// ---------------------------------------------
	localparam logic [7:0] DATA_PORT   = 8'hed;
	localparam logic [7:0] IDX_MAP     = 8'h03;
	localparam logic [7:0] IDX_CTL     = 8'h05;
	// ---------------------------------------------
	// Field positions and fixed bits
	// ---------------------------------------------
	localparam int         MAP_RELOC_HI = 6;
	localparam int         MAP_RELOC_LO = 5;
	localparam int         MAP_REMAP    = 4;
	localparam int         CTL_WAIT     = 4;
	localparam int         CTL_FAST_N   = 3;
	localparam int         CTL_PAGE_N   = 2;
	localparam int         CTL_PAR_N    = 1;
	localparam int         CTL_ROW_STROBE_SHUTOFF   = 0;
	localparam logic [0:0] MAP_FIXED    = 1'h1;
	localparam logic [2:0] CTL_FIXED    = 3'h7;
	// Reset values of the non-strap control bits
	localparam logic       FAST_N_RST   = 1'h0;
	localparam logic       PAR_N_RST    = 1'h0;
	localparam logic       ROW_STROBE_SHUTOFF_RST   = 1'h0;
	// ---------------------------------------------
	// Wait state timing
	// ---------------------------------------------
	localparam int         CLK_PER_WAIT = 2;
	localparam logic [1:0] WS_ZERO      = 2'h0;
	localparam logic [1:0] WS_BANK_MISS = 2'h1;
	localparam logic [1:0] WS_PAGE_MISS = 2'h2;
	localparam logic [1:0] WS_PAGE_SLOW = 2'h3;
	localparam logic [4:0] MEM_MIN_MB   = 5'h01;
	localparam logic [4:0] MEM_MAX_MB   = 5'h04;
	typedef enum logic [1:0] {
		CYC_PAGE_HIT,
		CYC_BANK_MISS,
		CYC_PAGE_MISS
	} dcr_cycle_type;
endpackage

/* File: hw/dcr_wait_timer.sv */
// Wait state timer for one DRAM access.
// Assumes start pulses arrive only while the timer is idle.
`timescale 1ns/100ps
module dcr_wait_timer #(
	parameter int CLK_PER_WAIT = 2
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic [1:0] waits,
	output logic            busy,
	output logic            ready
);
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic       busy_reg;
	logic       busy_next;
	logic       ready_reg;
	logic       ready_next;

	// ---------------------------------------------
	// Count two clock periods per wait state
	// ---------------------------------------------
	always_comb begin
		cnt_next   = cnt_reg;
		busy_next  = busy_reg;
		ready_next = 1'b0;
		if (start) begin
			cnt_next  = 4'(waits * CLK_PER_WAIT);
			busy_next = 1'b1;
		end else if (busy_reg) begin
			if (cnt_reg == 4'h0) begin
				busy_next  = 1'b0;
				ready_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - 4'h1;
			end
		end
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg   <= 4'h0;
			busy_reg  <= 1'b0;
			ready_reg <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			busy_reg  <= busy_next;
			ready_reg <= ready_next;
		end
	end

	assign busy  = busy_reg;
	assign ready = ready_reg;
endmodule

/* File: hw/dcr_regs.sv */
// DRAM map and cycle control registers behind the indexed data port.
// Assumes the index is held by the index port outside this block.
// Behaviour
// - Map at index 03h, control at 05h, through data port EDh
// - Map register bit 7 reads one, writes ignored
// - Relocation bits move C range to board, E range to slot
// - Relocation bits load from the two upper straps after reset
// - Remap bit moves the 384K region to top of memory
// - Remap acts only with 1M to 4M of memory
// - Remap bit loads from its strap after reset
// - Four map bits select the memory map, loaded from low straps
// - Control register bits 7-5 read one
// - One wait state lasts two clock periods
// - Wait bit adds one wait state to page-hit accesses, strap loaded
// - Page-miss bank-hit takes 2 or 3 waits by fast bit in zero wait mode
// - Page mode bit loads from its strap after reset
// - Parity bit zero enables parity generate and check, resets zero
// - Bank miss one wait, page-miss bank-hit two waits, three when slow in zero wait mode
`timescale 1ns/100ps
module dcr_regs #(
	parameter int DATA_W = 16
) (
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic [7:0]        IO_ADDR,
	input  wire logic              IO_WR,
	input  wire logic              IO_RD,
	input  wire logic [7:0]        CFG_INDEX,
	input  wire logic [7:0]        IO_WDATA,
	output logic      [7:0]        IO_RDATA,
	output logic                   IO_RVALID,
	input  wire logic [8:0]        STRAPS,
	input  wire logic [4:0]        TOTAL_MEM_MB,
	output logic      [3:0]        MAP_SELECT,
	output logic                   ROM_C_TO_BOARD,
	output logic                   ROM_E_TO_SLOT,
	output logic                   REMAP_ACTIVE,
	output logic                   PAGE_MODE_A,
	output logic                   PAGE_MODE_B,
	input  wire logic              CYC_START,
	input  wire logic [1:0]        CYC_KIND,
	output logic                   CYC_BUSY,
	output logic                   CYC_READY,
	input  wire logic [3:0]        RAS_REQ,
	input  wire logic [3:0]        RAS_HELD,
	output logic      [3:0]        RAS_ACTIVE,
	input  wire logic [DATA_W-1:0] DRAM_WDATA,
	output logic      [DATA_W/8-1:0] PAR_OUT,
	input  wire logic [DATA_W-1:0] DRAM_RDATA,
	input  wire logic [DATA_W/8-1:0] PAR_IN,
	input  wire logic              RD_CHECK,
	output logic                   PAR_ERR
);
	localparam int NB = DATA_W / 8;

	logic [6:0]    map_reg;
	logic [6:0]    map_next;
	logic [4:0]    ctl_reg;
	logic [4:0]    ctl_next;
	logic          boot_reg;
	logic          boot_next;
	logic [7:0]    rdata_reg;
	logic [7:0]    rdata_next;
	logic          rvalid_reg;
	logic          rvalid_next;
	logic [3:0]    ras_reg;
	logic [3:0]    ras_next;
	logic [NB-1:0] pout_reg;
	logic [NB-1:0] pout_next;
	logic          perr_reg;
	logic          perr_next;
	logic [NB-1:0] byte_bad;
	logic [1:0]    waits;
	logic          port_hit;
	logic          hit_map;
	logic          hit_ctl;

	// ---------------------------------------------
	// Register access
	// ---------------------------------------------
	// Decode of the data port and index
	assign port_hit = (IO_ADDR == dcr_pkg::DATA_PORT);
	assign hit_map  = port_hit && (CFG_INDEX == dcr_pkg::IDX_MAP);
	assign hit_ctl  = port_hit && (CFG_INDEX == dcr_pkg::IDX_CTL);

	// Next register values; strap capture happens once, on the first
	// clocked cycle after reset, so a write cannot race it
	always_comb begin
		map_next    = map_reg;
		ctl_next    = ctl_reg;
		boot_next   = 1'b0;
		rdata_next  = rdata_reg;
		rvalid_next = 1'b0;
		if (boot_reg) begin
			map_next = {STRAPS[8], STRAPS[7], STRAPS[4], STRAPS[3:0]};
			ctl_next = {STRAPS[5], dcr_pkg::FAST_N_RST, STRAPS[6],
				dcr_pkg::PAR_N_RST, dcr_pkg::ROW_STROBE_SHUTOFF_RST};
		end else if (IO_WR) begin
			if (hit_map) begin
				map_next = IO_WDATA[6:0];
			end
			if (hit_ctl) begin
				ctl_next = IO_WDATA[4:0];
			end
		end
		if (IO_RD && (hit_map || hit_ctl)) begin
			rvalid_next = 1'b1;
			if (hit_map) begin
				rdata_next = {dcr_pkg::MAP_FIXED, map_reg};
			end else begin
				rdata_next = {dcr_pkg::CTL_FIXED, ctl_reg};
			end
		end
	end

	// Registers only; the reset takes constants, straps come later
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			map_reg    <= 7'h00;
			ctl_reg    <= 5'h00;
			boot_reg   <= 1'b1;
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			map_reg    <= map_next;
			ctl_reg    <= ctl_next;
			boot_reg   <= boot_next;
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign IO_RDATA  = rdata_reg;
	assign IO_RVALID = rvalid_reg;

	// ---------------------------------------------
	// Map and page mode outputs
	// ---------------------------------------------
	// Remap is gated by memory size, so a stale bit is harmless
	assign MAP_SELECT     = map_reg[3:0];
	assign ROM_C_TO_BOARD = map_reg[dcr_pkg::MAP_RELOC_HI];
	assign ROM_E_TO_SLOT  = map_reg[dcr_pkg::MAP_RELOC_LO];
	assign REMAP_ACTIVE   = map_reg[dcr_pkg::MAP_REMAP] &&
		(TOTAL_MEM_MB >= dcr_pkg::MEM_MIN_MB) &&
		(TOTAL_MEM_MB <= dcr_pkg::MEM_MAX_MB);
	// Active-low bit: zero means page mode on
	assign PAGE_MODE_A    = !ctl_reg[dcr_pkg::CTL_PAGE_N];
	assign PAGE_MODE_B    = !ctl_reg[dcr_pkg::CTL_PAGE_N];

	// ---------------------------------------------
	// Wait state selection
	// ---------------------------------------------
	// Fast bit only matters in zero wait mode
	always_comb begin
		waits = dcr_pkg::WS_ZERO;
		case (dcr_pkg::dcr_cycle_type'(CYC_KIND))
			dcr_pkg::CYC_PAGE_HIT: begin
				waits = ctl_reg[dcr_pkg::CTL_WAIT] ? dcr_pkg::WS_BANK_MISS
					: dcr_pkg::WS_ZERO;
			end
			dcr_pkg::CYC_BANK_MISS: begin
				waits = dcr_pkg::WS_BANK_MISS;
			end
			dcr_pkg::CYC_PAGE_MISS: begin
				if (!ctl_reg[dcr_pkg::CTL_WAIT] && ctl_reg[dcr_pkg::CTL_FAST_N]) begin
					waits = dcr_pkg::WS_PAGE_SLOW;
				end else begin
					waits = dcr_pkg::WS_PAGE_MISS;
				end
			end
			default: begin
				waits = dcr_pkg::WS_BANK_MISS;
			end
		endcase
	end

	dcr_wait_timer #(
		.CLK_PER_WAIT (dcr_pkg::CLK_PER_WAIT)
	) u_wait (
		.clk   (CLK),
		.rst_n (RST_N),
		.start (CYC_START),
		.waits (waits),
		.busy  (CYC_BUSY),
		.ready (CYC_READY)
	);

	// ---------------------------------------------
	// Row strobes and parity
	// ---------------------------------------------
	// Shut-off trades a little speed for power in the idle bank
	always_comb begin
		ras_next = ctl_reg[dcr_pkg::CTL_ROW_STROBE_SHUTOFF] ? RAS_REQ
			: (RAS_REQ | RAS_HELD);
	end

	// Per-byte odd parity, gated by the active-low enable
	generate
		for (genvar b = 0; b < NB; b++) begin : g_par
			assign pout_next[b] = !ctl_reg[dcr_pkg::CTL_PAR_N] &&
				!(^DRAM_WDATA[b*8 +: 8]);
			assign byte_bad[b]  = (^{DRAM_RDATA[b*8 +: 8], PAR_IN[b]}) == 1'b0;
		end
	endgenerate

	// Errors only flag while checking is enabled
	assign perr_next = RD_CHECK && !ctl_reg[dcr_pkg::CTL_PAR_N] && (|byte_bad);

	// Registers only
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ras_reg  <= 4'h0;
			pout_reg <= '0;
			perr_reg <= 1'b0;
		end else begin
			ras_reg  <= ras_next;
			pout_reg <= pout_next;
			perr_reg <= perr_next;
		end
	end

	assign RAS_ACTIVE = ras_reg;
	assign PAR_OUT    = pout_reg;
	assign PAR_ERR    = perr_reg;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_map_top_one: assert property (
		(IO_RD && hit_map && !boot_reg) |=> IO_RVALID && IO_RDATA[7])
		else $error("Map bit 7 did not read one");

	a_ctl_top_ones: assert property (
		(IO_RD && hit_ctl && !hit_map) |=> IO_RDATA[7:5] == 3'h7)
		else $error("Control bits 7-5 did not read one");

	a_strap_capture: assert property (
		$rose(boot_reg == 1'b0) |-> MAP_SELECT == $past(STRAPS[3:0])
			&& ctl_reg[dcr_pkg::CTL_WAIT] == $past(STRAPS[5]))
		else $error("Straps not captured at reset release");

	a_map_write: assert property (
		(IO_WR && hit_map && !boot_reg) |=> MAP_SELECT == $past(IO_WDATA[3:0]))
		else $error("Map write not stored");

	a_remap_gate: assert property (
		(TOTAL_MEM_MB > 5'h04 || TOTAL_MEM_MB == 5'h00) |-> !REMAP_ACTIVE)
		else $error("Remap active with unsupported memory size");

	a_hit_nowait: assert property (
		(CYC_START && !CYC_BUSY && CYC_KIND == 2'h0 && !ctl_reg[4])
			|-> ##2 CYC_READY)
		else $error("Zero wait access not ready on time");

	a_slow_pagemiss: assert property (
		(CYC_START && !CYC_BUSY && CYC_KIND == 2'h2 && ctl_reg[4:3] == 2'h1)
			|-> !CYC_READY [*8] ##1 CYC_READY)
		else $error("Slow page miss not three wait states");

	a_bank_miss: assert property (
		(CYC_START && !CYC_BUSY && CYC_KIND == 2'h1) |-> ##4 CYC_READY)
		else $error("Bank miss not one wait state");

	a_ras_single: assert property (
		ctl_reg[dcr_pkg::CTL_ROW_STROBE_SHUTOFF] |=> $onehot0(RAS_ACTIVE) || !$onehot0($past(RAS_REQ)))
		else $error("More than one row strobe with shut-off");

	a_parity_off: assert property (
		ctl_reg[dcr_pkg::CTL_PAR_N] |=> !PAR_ERR)
		else $error("Parity error flagged while disabled");

	// Foreign port or index must stay silent on the read side
	a_read_refused: assert property (
		(IO_RD && !hit_map && !hit_ctl) |=> !IO_RVALID)
		else $error("Read valid for a foreign port or index");

	a_ctl_write: assert property (
		(IO_WR && hit_ctl && !boot_reg) |=> ctl_reg == $past(IO_WDATA[4:0]))
		else $error("Control write not stored");

	a_reloc_write: assert property (
		(IO_WR && hit_map && !boot_reg) |=> ROM_C_TO_BOARD == $past(IO_WDATA[6])
			&& ROM_E_TO_SLOT == $past(IO_WDATA[5]))
		else $error("Relocation bits not taken from write");

	a_page_pairs: assert property (
		(IO_WR && hit_ctl && !boot_reg) |=> PAGE_MODE_A == !$past(IO_WDATA[2])
			&& PAGE_MODE_B == !$past(IO_WDATA[2]))
		else $error("Page mode outputs disagree with written bit");

	a_remap_on: assert property (
		(map_reg[dcr_pkg::MAP_REMAP] && TOTAL_MEM_MB >= 5'h01 && TOTAL_MEM_MB <= 5'h04)
			|-> REMAP_ACTIVE)
		else $error("Remap bit set but remap not active");

	// Two waits: ready is sampled six edges after the start edge
	a_page_miss: assert property (
		(CYC_START && !CYC_BUSY && CYC_KIND == 2'h2 && ctl_reg[4:3] != 2'h1)
			|-> !CYC_READY [*6] ##1 CYC_READY)
		else $error("Page miss not two wait states");

	a_busy_start: assert property (
		(CYC_START && !CYC_BUSY) |=> CYC_BUSY)
		else $error("Timer not busy after start");

	a_parity_gen_off: assert property (
		ctl_reg[dcr_pkg::CTL_PAR_N] |=> PAR_OUT == '0)
		else $error("Parity generated while disabled");

	a_ras_both: assert property (
		!ctl_reg[dcr_pkg::CTL_ROW_STROBE_SHUTOFF]
			|=> RAS_ACTIVE == ($past(RAS_REQ) | $past(RAS_HELD)))
		else $error("Held row strobes dropped without shut-off");
endmodule

/* File: testbench/dcr_dram_model.sv */
// Behavioural DRAM word store on the far side of the parity logic.
// Assumes one word of storage is enough and writes are strobed by the bench.
`timescale 1ns/100ps
module dcr_dram_model (
	input  wire logic        clk,
	input  wire logic        wr,
	input  wire logic [15:0] wdata,
	input  wire logic        flip,
	output logic      [15:0] rdata,
	output logic      [1:0]  par
);
	logic [15:0] mem_reg;
	// ------------------------------------------------
	// Storage and stored odd parity
	// ------------------------------------------------
	// Store one word when strobed
	always_ff @(posedge clk) begin
		if (wr) begin
			mem_reg <= wdata;
		end
	end
	// Odd parity per byte; flip spoils the low byte to provoke an error
	assign rdata = mem_reg;
	assign par   = {~^mem_reg[15:8], (~^mem_reg[7:0]) ^ flip};
endmodule

/* File: testbench/dcr_regs_tb_top.sv */
// Self-checking bench for the DRAM configuration register pair.
// Assumes the design and the DRAM model are compiled first; 16-bit data.
`timescale 1ns/100ps
module dcr_regs_tb_top;
	logic        CLK, RST_N, IO_WR, IO_RD, CYC_START, RD_CHECK, IO_RVALID, flip, mwr;
	logic        ROM_C_TO_BOARD, ROM_E_TO_SLOT, REMAP_ACTIVE, PAGE_MODE_A, PAGE_MODE_B;
	logic        CYC_BUSY, CYC_READY, PAR_ERR;
	logic [7:0]  IO_ADDR, CFG_INDEX, IO_WDATA, IO_RDATA;
	logic [8:0]  STRAPS;
	logic [4:0]  TOTAL_MEM_MB;
	logic [3:0]  MAP_SELECT, RAS_REQ, RAS_HELD, RAS_ACTIVE;
	logic [1:0]  CYC_KIND, PAR_OUT, PAR_IN;
	logic [15:0] DRAM_WDATA, DRAM_RDATA;
	logic [23:0] rows [6];
	int          error_cnt, samples_checked, n;
	dcr_regs uut (.CLK(CLK), .RST_N(RST_N), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
		.CFG_INDEX(CFG_INDEX), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID),
		.STRAPS(STRAPS), .TOTAL_MEM_MB(TOTAL_MEM_MB), .MAP_SELECT(MAP_SELECT),
		.ROM_C_TO_BOARD(ROM_C_TO_BOARD), .ROM_E_TO_SLOT(ROM_E_TO_SLOT),
		.REMAP_ACTIVE(REMAP_ACTIVE), .PAGE_MODE_A(PAGE_MODE_A), .PAGE_MODE_B(PAGE_MODE_B),
		.CYC_START(CYC_START), .CYC_KIND(CYC_KIND), .CYC_BUSY(CYC_BUSY), .CYC_READY(CYC_READY),
		.RAS_REQ(RAS_REQ), .RAS_HELD(RAS_HELD), .RAS_ACTIVE(RAS_ACTIVE),
		.DRAM_WDATA(DRAM_WDATA), .PAR_OUT(PAR_OUT), .DRAM_RDATA(DRAM_RDATA), .PAR_IN(PAR_IN),
		.RD_CHECK(RD_CHECK), .PAR_ERR(PAR_ERR));
	dcr_dram_model mdl (.clk(CLK), .wr(mwr), .wdata(DRAM_WDATA), .flip(flip),
		.rdata(DRAM_RDATA), .par(PAR_IN));
	// ------------------------------------------------
	// Clock, shared tasks
	// ------------------------------------------------
	// 10 MHz clock
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		$display("errors=%0d checked=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Reset with given straps; first request may be driven after edge one
	task automatic do_reset(input logic [8:0] s);
		RST_N = 1'b0;
		STRAPS = s;
		repeat (3) @(negedge CLK);
		RST_N = 1'b1;
		@(negedge CLK);
	endtask
	// One write cycle at the data port
	task automatic wr(input logic [7:0] a, input logic [7:0] i, input logic [7:0] d);
		IO_WR = 1'b1;
		IO_ADDR = a;
		CFG_INDEX = i;
		IO_WDATA = d;
		@(negedge CLK);
		IO_WR = 1'b0;
		// Idle cycle so a following call never re-raises the strobe at once
		@(negedge CLK);
	endtask
	// One read; valid pulse and data looked at in the cycle after the taking edge
	task automatic rd(input logic [7:0] i, input logic v, input logic [7:0] e);
		IO_RD = 1'b1;
		IO_ADDR = 8'hed;
		CFG_INDEX = i;
		@(negedge CLK);
		IO_RD = 1'b0;
		chk(IO_RVALID, v);
		if (v) begin
			chk(IO_RDATA, e);
		end
		@(negedge CLK);
	endtask
	// Start one access and count cycles until ready
	task automatic cyc(input logic [1:0] k, input int e);
		CYC_START = 1'b1;
		CYC_KIND = k;
		@(negedge CLK);
		CYC_START = 1'b0;
		chk(CYC_BUSY, 1'b1);
		n = 0;
		while (CYC_READY !== 1'b1 && n < 20) begin
			@(negedge CLK);
			n++;
		end
		chk(16'(n), 16'(e));
		chk(CYC_BUSY, 1'b0);
		@(negedge CLK);
	endtask
	// Watchdog sized at many times the expected run
	initial begin
		#2000000;
		error_cnt++;
		end_of_test();
	end
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		{IO_WR, IO_RD, CYC_START, RD_CHECK, flip, mwr} = 6'h00;
		{IO_ADDR, CFG_INDEX, IO_WDATA} = 24'h000000;
		{CYC_KIND, RAS_REQ, RAS_HELD, DRAM_WDATA} = 26'h0000000;
		TOTAL_MEM_MB = 5'h02;
		error_cnt = 0;
		samples_checked = 0;
		// Rows: index, write data, expected read-back
		rows = '{24'h03_00_80, 24'h03_7f_ff, 24'h05_00_e0, 24'h05_ff_ff, 24'h05_0a_ea,
			24'h06_55_00};
		do_reset(9'h1a5);
		rd(8'h03, 1'b1, 8'he5);
		rd(8'h05, 1'b1, 8'hf0);
		chk({MAP_SELECT, ROM_C_TO_BOARD, ROM_E_TO_SLOT}, 6'h17);
		chk({PAGE_MODE_A, PAGE_MODE_B}, 2'h3);
		foreach (rows[r]) begin
			wr(8'hed, rows[r][23:16], rows[r][15:8]);
			rd(rows[r][23:16], rows[r][23:16] != 8'h06, rows[r][7:0]);
		end
		// Wrong port address must not store
		wr(8'hec, 8'h03, 8'h00);
		rd(8'h03, 1'b1, 8'hff);
		chk({MAP_SELECT, ROM_C_TO_BOARD, ROM_E_TO_SLOT}, 6'h3f);
		// Remap bit only acts with one to four megabytes
		for (int m = 0; m < 6; m++) begin
			TOTAL_MEM_MB = m[4:0];
			@(negedge CLK);
			chk(REMAP_ACTIVE, m >= 1 && m <= 4);
		end
		// Supported size, then clear the remap bit and split the two move bits
		TOTAL_MEM_MB = 5'h02;
		wr(8'hed, 8'h03, 8'h4f);
		chk(REMAP_ACTIVE, 1'b0);
		chk({MAP_SELECT, ROM_C_TO_BOARD, ROM_E_TO_SLOT}, 6'h3e);
		// Zero-wait mode, fast bit clear then set, then one-wait mode
		wr(8'hed, 8'h05, 8'h00);
		chk({PAGE_MODE_A, PAGE_MODE_B}, 2'h3);
		cyc(2'h0, 1);
		cyc(2'h1, 3);
		cyc(2'h2, 5);
		cyc(2'h2, 5);
		wr(8'hed, 8'h05, 8'h08);
		cyc(2'h2, 7);
		wr(8'hed, 8'h05, 8'h1c);
		chk({PAGE_MODE_A, PAGE_MODE_B}, 2'h0);
		cyc(2'h0, 3);
		cyc(2'h2, 5);
		// Row strobes with shut-off clear (bit 0 of 1c) then set
		RAS_REQ = 4'h2;
		RAS_HELD = 4'h1;
		@(negedge CLK);
		chk(RAS_ACTIVE, 4'h3);
		wr(8'hed, 8'h05, 8'h01);
		chk(RAS_ACTIVE, 4'h2);
		// Parity enabled: generate, store, check good and spoiled
		DRAM_WDATA = 16'h01f3;
		mwr = 1'b1;
		@(negedge CLK);
		mwr = 1'b0;
		chk(PAR_OUT, {~^DRAM_WDATA[15:8], ~^DRAM_WDATA[7:0]});
		for (int f = 0; f < 2; f++) begin
			flip = f[0];
			RD_CHECK = 1'b1;
			@(negedge CLK);
			RD_CHECK = 1'b0;
			chk(PAR_ERR, f[0]);
			@(negedge CLK);
		end
		// Parity disabled: no generation, no error
		wr(8'hed, 8'h05, 8'h02);
		RD_CHECK = 1'b1;
		@(negedge CLK);
		RD_CHECK = 1'b0;
		chk({PAR_OUT, PAR_ERR}, 3'h0);
		// Second reset with other straps replaces everything written
		do_reset(9'h05a);
		rd(8'h03, 1'b1, 8'h9a);
		chk({MAP_SELECT, ROM_C_TO_BOARD, ROM_E_TO_SLOT}, 6'h28);
		rd(8'h05, 1'b1, 8'he4);
		chk({PAGE_MODE_A, REMAP_ACTIVE}, 2'h1);
		end_of_test();
	end
endmodule
